// [verilog/feq_defs.vh]
`ifndef FEQ_DEFS_VH
`define FEQ_DEFS_VH

`define FEQ_ADDR_W          12
`define FEQ_DATA_W          24
`define FEQ_OFF_CENTER      12'h0450
`define FEQ_OFF_SIXTH       12'h0453
`define FEQ_OFF_SEVENTH     12'h0455
`define FEQ_OFF_EIGHTH      12'h0457
`define FEQ_OFF_NINTH       12'h0459
`define FEQ_CENTER_W        24
`define FEQ_OUTER_W         16
`define FEQ_CENTER_COEF_W   18
`define FEQ_OUTER_COEF_W    12
`define FEQ_RESET_VAL       24'h00_0000
`define FEQ_NINTH_MSB       11

`endif

// [verilog/feq_coeff_reg.v]
`include "feq_defs.vh"

module feq_coeff_reg #(
    parameter W = 16
) (
    input  wire         clk_sys_i,
    input  wire         resetn_i,
    input  wire         wr_en_i,
    input  wire [W-1:0] wdata_i,
    output wire [W-1:0] value_o
);
    reg [W-1:0] value_q;

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            value_q <= {W{1'b0}};
        else if (wr_en_i)
            value_q <= wdata_i;
    end

    assign value_o = value_q;
endmodule

// [verilog/feq_chan_b_upper_taps.v]
// The address-and-strobe port was left to the implementer.
`include "feq_defs.vh"

// How it works
// - centre coefficient 18-bit signed, bits 23:18 reserved
// - offset 0x450 feeds channel-B fifth tap
// - offset 0x453 bits 11:0 feed sixth tap
// - offset 0x455 bits 11:0 feed seventh tap
// - offset 0x457 bits 11:0 feed eighth tap
// - offset 0x459 bits 11:0 feed ninth tap
// - ninth tap readback returns MSB as zero
// - channel-B taps apply only in dual mode
module feq_chan_b_upper_taps #(
    parameter ADDR_W = `FEQ_ADDR_W,
    parameter DATA_W = `FEQ_DATA_W
) (
    input  wire                          clk_sys_i,
    input  wire                          resetn_i,
    input  wire [ADDR_W-1:0]             addr_i,
    input  wire [DATA_W-1:0]             wdata_i,
    input  wire                          wr_i,
    input  wire                          rd_i,
    input  wire                          dual_chan_i,
    output reg  [DATA_W-1:0]             rdata_o,
    output reg                           taps_active_o,
    output reg  [`FEQ_CENTER_COEF_W-1:0] tap5_coef_o,
    output reg  [`FEQ_OUTER_COEF_W-1:0]  tap6_coef_o,
    output reg  [`FEQ_OUTER_COEF_W-1:0]  tap7_coef_o,
    output reg  [`FEQ_OUTER_COEF_W-1:0]  tap8_coef_o,
    output reg  [`FEQ_OUTER_COEF_W-1:0]  tap9_coef_o
);
    localparam NOUT = 4;

    wire [`FEQ_CENTER_W-1:0] center_q;
    wire [`FEQ_OUTER_W-1:0]  outer_q [0:NOUT-1];
    wire [`FEQ_ADDR_W-1:0]   outer_off [0:NOUT-1];
    wire                     hit_center;
    wire [NOUT-1:0]          hit_outer;

    assign outer_off[0] = `FEQ_OFF_SIXTH;
    assign outer_off[1] = `FEQ_OFF_SEVENTH;
    assign outer_off[2] = `FEQ_OFF_EIGHTH;
    assign outer_off[3] = `FEQ_OFF_NINTH;

    assign hit_center = (addr_i == `FEQ_OFF_CENTER);

    // reserved bits are stored and read back as written
    feq_coeff_reg #(.W(`FEQ_CENTER_W)) u_center (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_en_i   (wr_i && hit_center),
        .wdata_i   (wdata_i[`FEQ_CENTER_W-1:0]),
        .value_o   (center_q)
    );

    genvar g;
    generate
        for (g = 0; g < NOUT; g = g + 1)
        begin : g_outer
            assign hit_outer[g] = (addr_i == outer_off[g]);
            feq_coeff_reg #(.W(`FEQ_OUTER_W)) u_reg (
                .clk_sys_i (clk_sys_i),
                .resetn_i  (resetn_i),
                .wr_en_i   (wr_i && hit_outer[g]),
                .wdata_i   (wdata_i[`FEQ_OUTER_W-1:0]),
                .value_o   (outer_q[g])
            );
        end
    endgenerate

    // coefficient fields as the datapath sees them; reserved bits stay behind
    wire [`FEQ_CENTER_COEF_W-1:0] center_coef;
    wire [`FEQ_OUTER_COEF_W-1:0]  outer_coef [0:NOUT-1];

    assign center_coef   = center_q[`FEQ_CENTER_COEF_W-1:0];
    assign outer_coef[0] = outer_q[0][`FEQ_OUTER_COEF_W-1:0];
    assign outer_coef[1] = outer_q[1][`FEQ_OUTER_COEF_W-1:0];
    assign outer_coef[2] = outer_q[2][`FEQ_OUTER_COEF_W-1:0];
    assign outer_coef[3] = outer_q[3][`FEQ_OUTER_COEF_W-1:0];

    reg [DATA_W-1:0]             rd_d;
    reg [DATA_W-1:0]             rdata_d;
    reg                          taps_active_d;
    reg [`FEQ_CENTER_COEF_W-1:0] tap5_d;
    reg [`FEQ_OUTER_COEF_W-1:0]  tap6_d;
    reg [`FEQ_OUTER_COEF_W-1:0]  tap7_d;
    reg [`FEQ_OUTER_COEF_W-1:0]  tap8_d;
    reg [`FEQ_OUTER_COEF_W-1:0]  tap9_d;

    // read path: unmapped offsets read as zero
    always @*
    begin
        rd_d = {DATA_W{1'b0}};
        case (addr_i)
            `FEQ_OFF_CENTER:
            begin
                rd_d = center_q;
            end
            `FEQ_OFF_SIXTH:
            begin
                rd_d = {{(DATA_W-`FEQ_OUTER_W){1'b0}}, outer_q[0]};
            end
            `FEQ_OFF_SEVENTH:
            begin
                rd_d = {{(DATA_W-`FEQ_OUTER_W){1'b0}}, outer_q[1]};
            end
            `FEQ_OFF_EIGHTH:
            begin
                rd_d = {{(DATA_W-`FEQ_OUTER_W){1'b0}}, outer_q[2]};
            end
            `FEQ_OFF_NINTH:
            begin
                rd_d = {{(DATA_W-`FEQ_OUTER_W){1'b0}}, outer_q[3]};
                // the stored bit still feeds the tap; only readback loses it
                rd_d[`FEQ_NINTH_MSB] = 1'b0;
            end
            default:
            begin
                rd_d = {DATA_W{1'b0}};
            end
        endcase
    end

    // read data stand for exactly the cycle after the strobe, else zero
    always @*
    begin
        rdata_d = {DATA_W{1'b0}};
        if (rd_i)
            rdata_d = rd_d;
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o <= {DATA_W{1'b0}};
        end
        else
        begin
            rdata_o <= rdata_d;
        end
    end

    // single-channel mode: zeros go out so a stale channel-B set
    // cannot leak into the filter that channel A drives alone
    always @*
    begin
        taps_active_d = 1'b0;
        tap5_d        = {`FEQ_CENTER_COEF_W{1'b0}};
        tap6_d        = {`FEQ_OUTER_COEF_W{1'b0}};
        tap7_d        = {`FEQ_OUTER_COEF_W{1'b0}};
        tap8_d        = {`FEQ_OUTER_COEF_W{1'b0}};
        tap9_d        = {`FEQ_OUTER_COEF_W{1'b0}};
        if (dual_chan_i)
        begin
            taps_active_d = 1'b1;
            tap5_d        = center_coef;
            tap6_d        = outer_coef[0];
            tap7_d        = outer_coef[1];
            tap8_d        = outer_coef[2];
            tap9_d        = outer_coef[3];
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            taps_active_o <= 1'b0;
        end
        else
        begin
            taps_active_o <= taps_active_d;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tap5_coef_o <= {`FEQ_CENTER_COEF_W{1'b0}};
        end
        else
        begin
            tap5_coef_o <= tap5_d;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tap6_coef_o <= {`FEQ_OUTER_COEF_W{1'b0}};
        end
        else
        begin
            tap6_coef_o <= tap6_d;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tap7_coef_o <= {`FEQ_OUTER_COEF_W{1'b0}};
        end
        else
        begin
            tap7_coef_o <= tap7_d;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tap8_coef_o <= {`FEQ_OUTER_COEF_W{1'b0}};
        end
        else
        begin
            tap8_coef_o <= tap8_d;
        end
    end

    always @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tap9_coef_o <= {`FEQ_OUTER_COEF_W{1'b0}};
        end
        else
        begin
            tap9_coef_o <= tap9_d;
        end
    end
endmodule

// [verification/feq_chan_b_upper_taps_checker.sv]
module feq_chan_b_upper_taps_checker (
    input wire logic        clk_sys_i,
    input wire logic        resetn_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic        dual_chan_i,
    input wire logic        taps_active_o,
    input wire logic [11:0] addr_i,
    input wire logic [23:0] wdata_i,
    input wire logic [23:0] rdata_o,
    input wire logic [17:0] tap5_coef_o,
    input wire logic [11:0] tap6_coef_o,
    input wire logic [11:0] tap7_coef_o,
    input wire logic [11:0] tap8_coef_o,
    input wire logic [11:0] tap9_coef_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    wire w5 = wr_i && addr_i == 12'h0450;
    wire w6 = wr_i && addr_i == 12'h0453;
    wire w7 = wr_i && addr_i == 12'h0455;
    wire w8 = wr_i && addr_i == 12'h0457;
    wire w9 = wr_i && addr_i == 12'h0459;
    wire r5 = rd_i && addr_i == 12'h0450;
    wire any_tap = |{tap5_coef_o, tap6_coef_o, tap7_coef_o, tap8_coef_o, tap9_coef_o};
    property p_t5;
        w5 ##1 dual_chan_i |=> tap5_coef_o == 18'($past(wdata_i, 2));
    endproperty
    a_t5: assert property (p_t5) else $error("tap5 bad");
    property p_t6;
        w6 ##1 dual_chan_i |=> tap6_coef_o == 12'($past(wdata_i, 2));
    endproperty
    a_t6: assert property (p_t6) else $error("tap6 bad");
    property p_t7;
        w7 ##1 dual_chan_i |=> tap7_coef_o == 12'($past(wdata_i, 2));
    endproperty
    a_t7: assert property (p_t7) else $error("tap7 bad");
    property p_t8;
        w8 ##1 dual_chan_i |=> tap8_coef_o == 12'($past(wdata_i, 2));
    endproperty
    a_t8: assert property (p_t8) else $error("tap8 bad");
    property p_t9;
        w9 ##1 dual_chan_i |=> tap9_coef_o == 12'($past(wdata_i, 2));
    endproperty
    a_t9: assert property (p_t9) else $error("tap9 bad");
    property p_crb;
        w5 ##1 r5 |=> rdata_o == $past(wdata_i, 2);
    endproperty
    a_crb: assert property (p_crb) else $error("centre readback bad");
    property p_rb9;
        rd_i && addr_i == 12'h0459 |=> !rdata_o[11] && rdata_o[23:16] == 8'h00;
    endproperty
    a_rb9: assert property (p_rb9) else $error("ninth readback bad");
    property p_off;
        !$past(dual_chan_i) |-> !any_tap;
    endproperty
    a_off: assert property (p_off) else $error("taps live in single mode");
    property p_mode; $past(resetn_i) |-> taps_active_o == $past(dual_chan_i); endproperty
    a_mode: assert property (p_mode) else $error("mode flag bad");
    cover property (w9 ##1 dual_chan_i);
    cover property (rd_i && addr_i == 12'h0459);
    cover property ($fell(dual_chan_i));
endmodule
bind feq_chan_b_upper_taps feq_chan_b_upper_taps_checker u_chk (.*);

// [verification/tb_top.sv]
`include "feq_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, dual_chan_i = 0, taps_active_o;
    logic [11:0] addr_i = 0, tap6_coef_o, tap7_coef_o, tap8_coef_o, tap9_coef_o, offs [5];
    logic [23:0] wdata_i = 0, rdata_o, q, d = 24'hDA_B9C8;
    logic [17:0] tap5_coef_o;
    int          n_errors = 0, check_count = 0, cyc = 0;
    feq_chan_b_upper_taps u_feq_chan_b_upper_taps (.*);
    initial forever #2 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (++cyc == 600) report_and_stop(1);
    task automatic chk(input logic [23:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [23:0] v);
        @(posedge clk_sys_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= v;
        @(posedge clk_sys_i);
        wr_i <= 0;
        rd_i <= 0;
        #1 q = rdata_o;
    endtask
    task automatic t_regs();
        offs = '{`FEQ_OFF_CENTER, `FEQ_OFF_SIXTH, `FEQ_OFF_SEVENTH,
                 `FEQ_OFF_EIGHTH, `FEQ_OFF_NINTH};
        for (int i = 0; i < 5; i++)
        begin
            bus(0, offs[i], 0);
            chk(q, 0);
            bus(1, offs[i], d);
            bus(0, offs[i], 0);
            chk(q, i == 0 ? d : {8'h00, d[15:0] & (i == 4 ? 16'hF7FF : 16'hFFFF)});
        end
        bus(1, 12'h0451, d);
        bus(0, 12'h0451, 0);
        chk(q, 0);
        $display("register test done");
    endtask
    task automatic t_taps();
        chk(tap5_coef_o, d[17:0]);
        chk(tap6_coef_o, d[11:0]);
        chk(tap7_coef_o, d[11:0]);
        chk(tap8_coef_o, d[11:0]);
        chk(tap9_coef_o, d[11:0]);
        chk(taps_active_o, 1);
        @(posedge clk_sys_i) dual_chan_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        #1 chk(tap5_coef_o | tap6_coef_o | tap7_coef_o | tap8_coef_o | tap9_coef_o, 0);
        chk(taps_active_o, 0);
        $display("tap test done");
    endtask
    task automatic report_and_stop(input logic hung);
        n_errors += hung;
        $display("%0d mismatches in %0d checks", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1;
        dual_chan_i <= 1;
        t_regs();
        t_taps();
        report_and_stop(0);
    end
endmodule
